// ===== verilog/lpdct_pkg.sv
// Constants, command codes and carrier types for the LPDDR command-timing controller.
// Assumes a 125 MHz system clock; the link clock is a divided copy driven out as the memory clock.
// Behaviour
// - After a status register read wait read latency plus one clocks before next command.
// - Give 15 ns write recovery after last write data, at least one clock.
// - Wait two clocks from write data end to READ, one on slowest grade.
// - After power-down exit wait two clocks (fast grades) or one before commands.
// - After self-refresh exit wait at least 120 ns before any command.
// - Toggle the memory clock at least twice during the self-refresh exit wait.
// - Change clock frequency only in clock stop, power-down or self refresh.
// - Auto-precharge write delay is ceil(recovery/period) plus ceil(precharge/period).
// - Refresh all rows within 64 ms, one refresh every 7.8125 us average.
// - Each data strobe covers one byte lane of the data bus.
// - Drive the strobe low from high impedance no later than the WRITE command.
// - Write preamble setup may be zero or negative at turnaround cost.
// - End the write strobe postamble between 0.4 and 0.6 clock periods; the strobe is released at its last falling edge, with no postamble.
// - In self refresh the clock-enable interval runs from a rising edge to enable high.
package lpdct_pkg;
   localparam int unsigned CLK_PERIOD_PS   = 8000;
   localparam int unsigned LINK_DIV        = 3;
   localparam int unsigned LINK_PERIOD_PS  = CLK_PERIOD_PS * 2 * LINK_DIV;
   localparam int unsigned WR_RECOVERY_PS  = 15000;
   localparam int unsigned PRECHARGE_PS    = 15000;
   localparam int unsigned SR_EXIT_PS      = 120000;
   localparam int unsigned REFRESH_INT_PS  = 7812500;
   localparam int unsigned SR_EXIT_TOGGLES = 2;
   localparam int unsigned WTR_CLKS        = 2;
   localparam int unsigned XP_CLKS         = 2;
   // Link-clock counts, rounded up from their times and never below one, except REFI_CLKS which rounds down
   function automatic int unsigned ceilClk(input int unsigned ps);
      int unsigned c;
      c = (ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int unsigned WR_CLKS  = ceilClk(WR_RECOVERY_PS);
   localparam int unsigned RP_CLKS  = ceilClk(PRECHARGE_PS);
   localparam int unsigned DAL_CLKS = WR_CLKS + RP_CLKS;
   localparam int unsigned XSR_CLKS = ceilClk(SR_EXIT_PS);
   localparam int unsigned REFI_CLKS = REFRESH_INT_PS / LINK_PERIOD_PS;
   localparam int unsigned CNT_W    = 8;
   localparam int unsigned NUM_BANKS = 4;

   typedef enum logic [2:0] {
      LPDCT_NOP, LPDCT_READ, LPDCT_WRITE, LPDCT_WRITE_AP, LPDCT_SRR_READ,
      LPDCT_REFRESH, LPDCT_PD_ENTER, LPDCT_SR_ENTER
   } lpdct_cmd_t;

   typedef struct packed {
      lpdct_cmd_t cmd;
      logic [1:0] bank;
      logic       exitLow;
   } lpdct_req_t;

   typedef struct packed {
      logic [2:0] cmdPins;
      logic [1:0] bankPins;
      logic       clockEnable;
   } lpdct_pins_t;
endpackage

// ===== verilog/lpdct_sync.sv
// Toggle-based event crossing into a destination clock domain.
// Assumes the source toggles no faster than the destination can sample.
`timescale 1ns/100ps
module lpdct_sync (
   input  wire logic clock,     // Destination clock
   input  wire logic sys_rst,   // Async reset
   input  wire logic toggleIn,  // Source toggle
   output logic      pulseOut   // One-cycle pulse per toggle
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end else begin
         stage1_reg <= toggleIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end
   assign pulseOut = stage2_reg ^ stage3_reg;
endmodule // lpdct_sync

// ===== verilog/lpdct_ctrl.sv
// Host-side command-timing controller for a low-power DDR memory.
// Assumes requests arrive on clock; the link logic runs on the divided memory clock linkClock.
`timescale 1ns/100ps
module lpdct_ctrl import lpdct_pkg::*; #(
   parameter int unsigned READ_LATENCY = 3,          // Read latency setting, 2 or 3
   parameter int unsigned REFI_COUNT   = REFI_CLKS,  // Refresh interval in link clocks
   parameter int unsigned DQ_WIDTH     = 16          // 16 or 32
) (
   input  wire logic                  clock,         // System clock
   input  wire logic                  sys_rst,       // Async reset
   input  wire lpdct_req_t            reqIn,         // Command request
   input  wire logic                  reqValid,      // Request valid
   output logic                       reqReady,      // Request accepted
   output logic                       linkClock,     // Divided memory clock out
   output lpdct_pins_t                memPins,       // Command pins
   output logic [DQ_WIDTH/8-1:0]      strobeOut,     // Per-byte strobe out
   output logic [DQ_WIDTH/8-1:0]      strobeOe,      // Per-byte strobe enable
   input  wire logic [DQ_WIDTH-1:0]   dataIn,        // Read data pins
   output logic [DQ_WIDTH-1:0]        readData,      // Captured read data
   output logic                       readValid,     // Read data pulse
   output logic                       busyOut        // Link not idle
);
   localparam int unsigned LANES = DQ_WIDTH / 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock divider: the memory clock may only stop while idle in power states
   logic [1:0] divCnt_reg;
   logic       linkClk_reg;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         divCnt_reg  <= 2'h0;
         linkClk_reg <= 1'b0;
      end else if (divCnt_reg == 2'(LINK_DIV - 1)) begin
         divCnt_reg  <= 2'h0;
         linkClk_reg <= ~linkClk_reg;
      end else begin
         divCnt_reg <= divCnt_reg + 2'h1;
      end
   end
   assign linkClock = linkClk_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Request hand-off into the link domain
   logic       reqTog_reg;
   logic       ackTog_reg;
   logic       pending_reg;
   lpdct_req_t reqHold_reg;
   logic       ackPulse;
   logic       linkReqPulse;
   assign reqReady = ~pending_reg;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reqTog_reg  <= 1'b0;
         pending_reg <= 1'b0;
         reqHold_reg <= '0;
      end else if (reqValid && !pending_reg) begin
         reqTog_reg  <= ~reqTog_reg;
         pending_reg <= 1'b1;
         reqHold_reg <= reqIn;
      end else if (ackPulse) begin
         pending_reg <= 1'b0;
      end
   end
   lpdct_sync reqSync (.clock(linkClock), .sys_rst(sys_rst), .toggleIn(reqTog_reg), .pulseOut(linkReqPulse));
   lpdct_sync ackSync (.clock(clock), .sys_rst(sys_rst), .toggleIn(ackTog_reg), .pulseOut(ackPulse));

   ////////////////////////////////////////////////////////////////////////////////
   // Link-domain timing state
   typedef enum logic [2:0] {LPDCT_IDLE, LPDCT_PWRDN, LPDCT_SELFREF, LPDCT_EXIT, LPDCT_WRDATA} lpdct_state_t;
   lpdct_state_t state_reg;
   lpdct_state_t state_next;
   logic [CNT_W-1:0] gapCnt_reg;
   logic [CNT_W-1:0] gapCnt_next;
   logic [CNT_W-1:0] wtrCnt_reg;
   logic [CNT_W-1:0] bankCnt_reg [NUM_BANKS];
   logic [15:0]      refiCnt_reg;
   logic [READ_LATENCY+2:0] rdPipe_reg;
   logic [2:0]       exitToggles_reg;
   logic             cmdAcc;
   logic             reqHeld_reg;
   lpdct_req_t       req;
   logic             bankFree;
   logic             refreshDue;
   lpdct_pins_t      pins_next;
   logic [LANES-1:0] strobeOe_reg;

   assign req        = reqHold_reg;  // Stable while pending, sampled after the synced pulse
   assign bankFree   = bankCnt_reg[req.bank] == '0;
   assign refreshDue = refiCnt_reg == 16'(REFI_COUNT - 1);
   assign cmdAcc     = reqHeld_reg && state_reg == LPDCT_IDLE && gapCnt_reg == '0 && bankFree
                       && !(req.cmd == LPDCT_READ && wtrCnt_reg != '0);

   always_comb begin
      state_next = state_reg;
      gapCnt_next = (gapCnt_reg != '0) ? gapCnt_reg - 1'b1 : gapCnt_reg;
      pins_next = '{cmdPins: 3'(LPDCT_NOP), bankPins: 2'h0, clockEnable: 1'b1};
      unique case (state_reg)
         LPDCT_IDLE: begin
            if (cmdAcc) begin
               pins_next.cmdPins  = 3'(req.cmd);
               pins_next.bankPins = req.bank;
               unique case (req.cmd)
                  LPDCT_SRR_READ: gapCnt_next = CNT_W'(READ_LATENCY + 1);
                  LPDCT_WRITE, LPDCT_WRITE_AP: state_next = LPDCT_WRDATA;
                  LPDCT_PD_ENTER: state_next = LPDCT_PWRDN;
                  LPDCT_SR_ENTER: state_next = LPDCT_SELFREF;
                  default: ;
               endcase
            end else if (refreshDue && gapCnt_reg == '0) begin
               pins_next.cmdPins = 3'(LPDCT_REFRESH);
            end
         end
         LPDCT_WRDATA: state_next = LPDCT_IDLE;
         // Frequency changes are legal only while parked here
         LPDCT_PWRDN, LPDCT_SELFREF: begin
            pins_next.clockEnable = 1'b0;
            if (reqHeld_reg && req.exitLow) begin
               pins_next.clockEnable = 1'b1;
               state_next = LPDCT_EXIT;
               gapCnt_next = (state_reg == LPDCT_SELFREF) ? CNT_W'(XSR_CLKS) : CNT_W'(XP_CLKS);
            end
         end
         LPDCT_EXIT: begin
            if (gapCnt_reg <= 1 && exitToggles_reg >= 3'(SR_EXIT_TOGGLES)) begin
               state_next = LPDCT_IDLE;
               gapCnt_next = '0;
            end
         end
      endcase
   end

   always_ff @(posedge linkClock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= LPDCT_IDLE;
         gapCnt_reg <= '0;
         memPins <= '{cmdPins: 3'(LPDCT_NOP), bankPins: 2'h0, clockEnable: 1'b0};
         reqHeld_reg <= 1'b0;
         ackTog_reg <= 1'b0;
         exitToggles_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         gapCnt_reg <= gapCnt_next;
         memPins <= pins_next;
         exitToggles_reg <= (state_reg == LPDCT_EXIT) ? exitToggles_reg + ((exitToggles_reg < 3'h7) ? 3'h1 : 3'h0) : 3'h0;
         if (linkReqPulse) reqHeld_reg <= 1'b1;
         else if (cmdAcc || state_next == LPDCT_EXIT && state_reg != LPDCT_EXIT) begin
            reqHeld_reg <= 1'b0;
            ackTog_reg <= ~ackTog_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bank recovery counters, plus shared write-to-read and refresh counters
   genvar b;
   for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge linkClock or posedge sys_rst) begin
         if (sys_rst) bankCnt_reg[b] <= '0;
         else if (cmdAcc && req.bank == 2'(b) && req.cmd == LPDCT_WRITE_AP) bankCnt_reg[b] <= CNT_W'(DAL_CLKS);
         else if (cmdAcc && req.bank == 2'(b) && req.cmd == LPDCT_WRITE) bankCnt_reg[b] <= CNT_W'(WR_CLKS + 1);
         else if (bankCnt_reg[b] != '0) bankCnt_reg[b] <= bankCnt_reg[b] - 1'b1;
      end
   end
   always_ff @(posedge linkClock or posedge sys_rst) begin
      if (sys_rst) begin
         wtrCnt_reg <= '0;
         refiCnt_reg <= 16'h0;
      end else begin
         if (state_reg == LPDCT_WRDATA) wtrCnt_reg <= CNT_W'(WTR_CLKS);
         else if (wtrCnt_reg != '0) wtrCnt_reg <= wtrCnt_reg - 1'b1;
         refiCnt_reg <= (refreshDue && state_reg == LPDCT_IDLE && !cmdAcc && gapCnt_reg == '0) ? 16'h0 :
                        refreshDue ? refiCnt_reg : refiCnt_reg + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Strobes: driven low from the falling edge after the WRITE edge, high for half a clock, released at the next falling edge with no postamble
   genvar l;
   for (l = 0; l < LANES; l++) begin : g_lane
      always_ff @(negedge linkClock or posedge sys_rst) begin
         if (sys_rst) begin
            strobeOe_reg[l] <= 1'b0;
         end else begin
            strobeOe_reg[l] <= state_reg == LPDCT_WRDATA;
         end
      end
   end
   assign strobeOut = strobeOe_reg & {LANES{linkClock}};
   assign strobeOe  = strobeOe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Read capture after the read latency; the pin is seen one clock after the memory
   // registers the command and the two input flops add two more clocks
   logic [DQ_WIDTH-1:0] dq1_reg;
   logic [DQ_WIDTH-1:0] dq2_reg;
   always_ff @(posedge linkClock or posedge sys_rst) begin
      if (sys_rst) begin
         rdPipe_reg <= '0;
         dq1_reg <= '0;
         dq2_reg <= '0;
         readData <= '0;
         readValid <= 1'b0;
      end else begin
         rdPipe_reg <= {rdPipe_reg[READ_LATENCY+1:0], cmdAcc && (req.cmd == LPDCT_READ || req.cmd == LPDCT_SRR_READ)};
         dq1_reg <= dataIn;
         dq2_reg <= dq1_reg;
         readValid <= rdPipe_reg[READ_LATENCY+2];
         if (rdPipe_reg[READ_LATENCY+2]) readData <= dq2_reg;
      end
   end
   assign busyOut = state_reg != LPDCT_IDLE;

   srr_gap_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      cmdAcc && req.cmd == LPDCT_SRR_READ |=> !cmdAcc [*4]) else $error("command too soon after status read");
   exit_wait_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      state_reg == LPDCT_SELFREF && state_next == LPDCT_EXIT |=> !cmdAcc [*3]) else $error("self refresh exit too short");
   wtr_gap_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      state_reg == LPDCT_WRDATA |=> !(cmdAcc && req.cmd == LPDCT_READ) [*2]) else $error("read too soon after write");
   bank_block_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      cmdAcc && req.cmd == LPDCT_WRITE_AP |=> bankCnt_reg[$past(req.bank)] == CNT_W'(DAL_CLKS)) else $error("bank delay not loaded");
   cke_low_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      state_reg == LPDCT_PWRDN && state_next == LPDCT_PWRDN |=> !memPins.clockEnable) else $error("clock enable high in power down");
   refresh_issue_a: assert property (@(posedge linkClock) disable iff (sys_rst)
      refreshDue && state_reg == LPDCT_IDLE && gapCnt_reg == '0 && !cmdAcc |=> memPins.cmdPins == 3'(LPDCT_REFRESH))
      else $error("refresh not issued when due");
endmodule // lpdct_ctrl

// ===== tb/lpdct_mem_model.sv
// Behavioural memory device on the far side of the command-timing controller.
// Assumes cmdPins carries the command code, sampled on rising linkClock edges.
`timescale 1ns/100ps
module lpdct_mem_model import lpdct_pkg::*; #(
   parameter int unsigned READ_LATENCY = 3,  // Read latency setting
   parameter int unsigned DQ_WIDTH     = 16  // Data bus width
) (
   input  wire logic           linkClock,    // Memory clock
   input  wire logic           sys_rst,      // Async reset
   input  wire lpdct_pins_t    memPins,      // Command pins
   output logic [DQ_WIDTH-1:0] dataOut,      // Read data pins
   output logic [7:0]          violCount,    // Spacing violations
   output logic [7:0]          refreshCount  // Refreshes seen
);
   lpdct_cmd_t          lastCmd;
   logic [15:0]         gap;
   logic [1:0]          rdCnt;
   logic                ckePrev, inPd, inSr, exPd, exSr;
   wire  [DQ_WIDTH-1:0] pattern;
   wire lpdct_cmd_t     cmdNow  = lpdct_cmd_t'(memPins.cmdPins);
   wire                 isCmd   = memPins.clockEnable && cmdNow != LPDCT_NOP;
   wire                 ckeRise = memPins.clockEnable && !ckePrev;
   wire                 isRead  = cmdNow == LPDCT_READ || cmdNow == LPDCT_SRR_READ;
   wire logic [31:0]    need    = exSr ? XSR_CLKS :
                                  exPd ? XP_CLKS :
                                  lastCmd == LPDCT_SRR_READ ? READ_LATENCY + 1 :
                                  lastCmd == LPDCT_WRITE_AP ? DAL_CLKS :
                                  (lastCmd == LPDCT_WRITE && cmdNow == LPDCT_READ) ? WTR_CLKS : 1;
   for (genvar g = 0; g < DQ_WIDTH / 8; g++) begin : g_lane
      assign pattern[8*g +: 8] = 8'(8'h11 * (g + 1));
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge linkClock or posedge sys_rst) begin
      if (sys_rst) begin
         lastCmd <= LPDCT_NOP;
         {gap, rdCnt, ckePrev, inPd, inSr, exPd, exSr} <= '0;
         {dataOut, violCount, refreshCount} <= '0;
      end else begin
         ckePrev <= memPins.clockEnable;
         gap     <= (isCmd || ckeRise) ? 16'h0 : gap + 16'h1;
         if (isCmd) lastCmd <= cmdNow;
         if (isCmd && 32'(gap) + 1 < need) violCount <= violCount + 8'h1;
         if (isCmd && cmdNow == LPDCT_REFRESH) refreshCount <= refreshCount + 8'h1;
         inPd <= (isCmd && cmdNow == LPDCT_PD_ENTER) || (inPd && !ckeRise);
         inSr <= (isCmd && cmdNow == LPDCT_SR_ENTER) || (inSr && !ckeRise);
         exPd <= ckeRise ? inPd : exPd && !isCmd;
         exSr <= ckeRise ? inSr : exSr && !isCmd;
         // Read data lands latency-minus-one clocks after the command, else the bus churns
         rdCnt   <= (isCmd && isRead) ? 2'(READ_LATENCY - 1) : (rdCnt != 2'h0 ? rdCnt - 2'h1 : 2'h0);
         dataOut <= (rdCnt == 2'h1) ? pattern : ~dataOut;
      end
   end
endmodule // lpdct_mem_model

// ===== tb/lpdct_ctrl_tb.sv
// Self-checking bench for the LPDDR command-timing controller.
// Assumes lpdct_mem_model stands at the memory pins and counts spacing faults.
`timescale 1ns/100ps
module lpdct_ctrl_tb import lpdct_pkg::*; ();
   localparam int unsigned REFI     = 50;
   localparam logic [15:0] EXP_DATA = 16'h2211;  // Lane 0 carries 8'h11, lane 1 8'h22
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   lpdct_req_t  reqIn = '0;
   logic        reqValid = 1'b0;
   logic        reqReady, linkClock, readValid, busyOut;
   lpdct_pins_t memPins;
   logic [1:0]  strobeOut, strobeOe, prevOe;
   logic [15:0] dataIn, readData;
   logic [7:0]  violCount, refreshCount;
   int          badCount = 0, nCompared = 0, strobeRises = 0;
   realtime     lastEdge = 0;
   always #4 clock = ~clock;
   lpdct_ctrl #(.READ_LATENCY(3), .REFI_COUNT(REFI), .DQ_WIDTH(16)) lpdct_ctrl_i (.clock(clock),
      .sys_rst(sys_rst), .reqIn(reqIn), .reqValid(reqValid), .reqReady(reqReady), .linkClock(linkClock),
      .memPins(memPins), .strobeOut(strobeOut), .strobeOe(strobeOe), .dataIn(dataIn), .readData(readData),
      .readValid(readValid), .busyOut(busyOut));
   lpdct_mem_model #(.READ_LATENCY(3), .DQ_WIDTH(16)) lpdct_mem_model_i (.linkClock(linkClock),
      .sys_rst(sys_rst), .memPins(memPins), .dataOut(dataIn), .violCount(violCount), .refreshCount(refreshCount));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout();
      check(32'h0, 32'h1);
      stop_test();
   endtask
   always @(negedge clock) begin
      if (!sys_rst && (strobeOe & ~prevOe & strobeOut) !== 2'h0) check(32'(strobeOut), 32'h0);
      if (!sys_rst && (strobeOe & ~prevOe) !== 2'h0) strobeRises++;
      prevOe = strobeOe;
   end
   always @(posedge linkClock) begin
      if (!sys_rst && memPins.clockEnable === 1'b1 && lastEdge > 0 && $realtime - lastEdge != 48.0)
         check(32'($rtoi($realtime - lastEdge)), 32'd48);
      lastEdge = $realtime;
   end
   task automatic send(input lpdct_cmd_t cmd, input logic exitLow);
      @(negedge clock);
      reqIn = '{cmd: cmd, bank: 2'h1, exitLow: exitLow};
      reqValid = 1'b1;
      for (int n = 0; n < 5000 && reqReady !== 1'b1; n++) @(negedge clock);
      if (reqReady !== 1'b1) timeout();
      @(negedge clock);
      reqValid = 1'b0;
   endtask
   task automatic wait_read();
      for (int n = 0; n < 5000 && readValid !== 1'b1; n++) @(negedge clock);
      if (readValid !== 1'b1) timeout();
      check(32'(readData), 32'(EXP_DATA));
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 5000 && !(busyOut === 1'b0 && readValid === 1'b0 && reqReady === 1'b1); n++)
         @(negedge clock);
      if (busyOut !== 1'b0) timeout();
      check(32'(violCount), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_srr();
      send(LPDCT_SRR_READ, 1'b0);
      send(LPDCT_READ, 1'b0);
      wait_read();
      wait_idle();
      $display("Test status read then read done");
   endtask
   task automatic t_write();
      int r0;
      r0 = strobeRises;
      send(LPDCT_WRITE, 1'b0);
      send(LPDCT_READ, 1'b0);
      wait_read();
      send(LPDCT_WRITE_AP, 1'b0);
      send(LPDCT_READ, 1'b0);
      wait_idle();
      check(32'(strobeRises - r0 >= 2), 32'h1);
      $display("Test write turnaround done");
   endtask
   task automatic t_sleep(input lpdct_cmd_t mode);
      send(mode, 1'b0);
      for (int n = 0; n < 5000 && memPins.clockEnable !== 1'b0; n++) @(negedge clock);
      check(32'(memPins.clockEnable), 32'h0);
      send(LPDCT_NOP, 1'b1);
      send(LPDCT_READ, 1'b0);
      wait_read();
      wait_idle();
      $display("Test sleep exit done");
   endtask
   task automatic t_refresh();
      logic [7:0] r0;
      r0 = refreshCount;
      repeat (3 * REFI * 2 * LINK_DIV) @(negedge clock);
      check(32'(refreshCount - r0 >= 8'h2), 32'h1);
      $display("Test refresh cadence done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      send(LPDCT_READ, 1'b0);
      wait_read();
      wait_idle();
      $display("Test read latency done");
      t_srr();
      t_write();
      t_sleep(LPDCT_PD_ENTER);
      t_sleep(LPDCT_SR_ENTER);
      t_refresh();
      stop_test();
   end
endmodule // lpdct_ctrl_tb
